// File: inc/fbio_pkg.sv
package fbio_pkg;
    // register numbers serve directly as word addresses
    localparam logic [15:0] FBIO_ADDR_CMD = 16'h07D6;       // 2006, write-only command word
    localparam logic [15:0] FBIO_ADDR_STATUS = 16'h1F3C;    // 7996
    localparam logic [15:0] FBIO_ADDR_DIAG = 16'h1F3D;      // 7997
    localparam logic [15:0] FBIO_ADDR_FAULT_LOC = 16'h1F3E; // 7998
    localparam logic [15:0] FBIO_ADDR_INPUT = 16'h1F40;     // 8000
    localparam logic [15:0] FBIO_ADDR_OUTPUT = 16'h2328;    // 9000
    localparam logic [15:0] FBIO_ADDR_WDOG = 16'h2000;      // watchdog timeout word
    // fault location codes
    localparam logic [15:0] FBIO_LOC_NONE = 16'h0000;
    localparam logic [15:0] FBIO_LOC_LOW = 16'h0001;
    localparam logic [15:0] FBIO_LOC_HIGH = 16'h0002;
    // bit positions and fixed values
    localparam int FBIO_DIAG_SHORT_BIT = 0;
    localparam int FBIO_STAT_ERR_BIT = 0;
    localparam int FBIO_CMD_CLEAR_BIT = 7;
    localparam logic [3:0] FBIO_ROTARY_DEFAULTS = 4'hF;
    localparam logic [7:0] FBIO_BYTE_ZERO = 8'h00;
    localparam logic [15:0] FBIO_WDOG_RESET = 16'h0000;
    // timing
    localparam int FBIO_CLK_HZ = 20_000_000;
    localparam int FBIO_CONN_READY_MS = 350;
    localparam int FBIO_CYCLIC_READY_MS = 500;
    // longest times round down; connection ready ahead of the bound
    localparam int FBIO_CONN_CYCLES = FBIO_CLK_HZ / 1000 * FBIO_CONN_READY_MS - 1;
    localparam int FBIO_CYCLIC_CYCLES = FBIO_CLK_HZ / 1000 * FBIO_CYCLIC_READY_MS - 1;
    localparam int FBIO_BLINK_HALF_MS = 250;
    localparam int FBIO_BLINK_CYCLES = FBIO_CLK_HZ / 1000 * FBIO_BLINK_HALF_MS;

    typedef struct packed {
        logic wr;          // one-cycle write strobe
        logic rd;          // one-cycle read strobe
        logic [15:0] addr; // register number
        logic [15:0] wdata;
    } fbio_req_t;

    typedef struct packed {
        logic green;
        logic yellow;
    } fbio_lamp_t;
endpackage

// File: verilog/fbio_regs.sv
`timescale 1ns/1ns
module fbio_regs import fbio_pkg::*; #(
    parameter int CONN_CYCLES = FBIO_CONN_CYCLES,
    parameter int CYCLIC_CYCLES = FBIO_CYCLIC_CYCLES,
    parameter int BLINK_CYCLES = FBIO_BLINK_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire fbio_req_t i_req,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    output logic o_cmd_error,
    input wire logic [7:0] i_device_input,
    output logic [7:0] o_device_output,
    input wire logic [1:0] i_short_group,
    input wire logic [3:0] i_rotary,
    input wire logic i_fw_update,
    output logic o_restore_defaults,
    output logic o_conn_ready,
    output logic o_cyclic_ready,
    output logic [15:0] o_wdog_timeout,
    output logic o_wdog_auto_confirm,
    output fbio_lamp_t o_net_lamp,
    output fbio_lamp_t o_rdy_lamp
);
    // output image and watchdog timeout, both configuration
    logic [7:0] out_image, next_out_image;
    logic [15:0] wdog, next_wdog;
    // latched short groups, kept until a clear command finds them gone
    logic [1:0] fault_grp, next_fault_grp;
    // command error flag
    logic cmd_err, next_cmd_err;
    // read port
    logic [15:0] rdata, next_rdata;
    logic rvalid, next_rvalid;
    // boot timer, counts up once and then rests
    logic [31:0] boot_cnt, next_boot_cnt;
    // lamp divider and the slow toggle it steps
    logic [31:0] blink_cnt, next_blink_cnt;
    logic blink_tick;
    logic blink, next_blink;
    // register words as the client reads them
    logic [15:0] fault_group_location;
    logic [15:0] input_image_word;
    logic [15:0] output_image_word;
    logic [15:0] diag_word;
    logic [15:0] status_word;
    logic short_any;
    // write decode
    logic cmd_wr, cmd_one_hot, cmd_clear;
    logic out_wr, wdog_wr;
    logic restore;

    // full address compare; anything else falls through and is ignored
    assign cmd_wr = i_req.wr && (i_req.addr == FBIO_ADDR_CMD);
    assign cmd_one_hot = $onehot(i_req.wdata);
    assign cmd_clear = cmd_wr && cmd_one_hot && i_req.wdata[FBIO_CMD_CLEAR_BIT];
    assign out_wr = i_req.wr && (i_req.addr == FBIO_ADDR_OUTPUT);
    assign wdog_wr = i_req.wr && (i_req.addr == FBIO_ADDR_WDOG);
    // the switch is a level: defaults are held for as long as it sits at 0F
    assign restore = (i_rotary == FBIO_ROTARY_DEFAULTS);

    // group code, never per channel; low group wins if both are shorted
    always_comb begin
        if (fault_grp[0]) begin
            fault_group_location = FBIO_LOC_LOW;
        end else if (fault_grp[1]) begin
            fault_group_location = FBIO_LOC_HIGH;
        end else begin
            fault_group_location = FBIO_LOC_NONE;
        end
    end

    // byte-wide items sit in the low byte; the high byte reads zero
    assign input_image_word = {FBIO_BYTE_ZERO, i_device_input};
    assign output_image_word = {FBIO_BYTE_ZERO, out_image};
    // both flag words show the latched short, so they agree with the location
    assign short_any = |fault_grp;
    assign diag_word = 16'(short_any) << FBIO_DIAG_SHORT_BIT;
    assign status_word = 16'(short_any) << FBIO_STAT_ERR_BIT;

    // output image and watchdog; the switch overrides a write in the same cycle
    always_comb begin
        next_out_image = out_image;
        next_wdog = wdog;
        if (out_wr) begin
            next_out_image = i_req.wdata[7:0]; // high byte discarded
        end
        if (wdog_wr) begin
            next_wdog = i_req.wdata; // word kept 1:1
        end
        if (restore) begin
            next_out_image = FBIO_BYTE_ZERO;
            next_wdog = FBIO_WDOG_RESET;
        end
    end

    // configuration registers
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            out_image <= FBIO_BYTE_ZERO;
            wdog <= FBIO_WDOG_RESET;
        end else begin
            out_image <= next_out_image;
            wdog <= next_wdog;
        end
    end

    // new shorts set; a clear reloads from the live inputs, so set wins
    always_comb begin
        next_fault_grp = fault_grp | i_short_group;
        if (cmd_clear) begin
            next_fault_grp = i_short_group;
        end
    end

    // fault latch register
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            fault_grp <= 2'h0;
        end else begin
            fault_grp <= next_fault_grp;
        end
    end

    // error flag follows the last command write only
    always_comb begin
        next_cmd_err = cmd_err;
        if (cmd_wr) begin
            next_cmd_err = !cmd_one_hot;
        end
    end

    // command error register
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cmd_err <= 1'b0;
        end else begin
            cmd_err <= next_cmd_err;
        end
    end

    // read port: data captured at the strobe edge and held until the next read
    always_comb begin
        next_rvalid = i_req.rd;
        next_rdata = rdata;
        if (i_req.rd) begin
            case (i_req.addr)
                FBIO_ADDR_FAULT_LOC: next_rdata = fault_group_location;
                FBIO_ADDR_INPUT: next_rdata = input_image_word;
                FBIO_ADDR_OUTPUT: next_rdata = output_image_word;
                FBIO_ADDR_DIAG: next_rdata = diag_word;
                FBIO_ADDR_STATUS: next_rdata = status_word;
                FBIO_ADDR_WDOG: next_rdata = wdog;
                default: next_rdata = 16'h0000; // unmapped and write-only read zero
            endcase
        end
    end

    // read data and its valid flag
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rdata <= 16'h0000;
            rvalid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // boot timer stops at the longer bound so it never wraps
    always_comb begin
        next_boot_cnt = boot_cnt;
        if (boot_cnt < 32'(CYCLIC_CYCLES)) begin
            next_boot_cnt = boot_cnt + 32'h1;
        end
    end

    // boot timer register
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            boot_cnt <= 32'h0;
        end else begin
            boot_cnt <= next_boot_cnt;
        end
    end

    // lamp divider: a one-cycle enable every BLINK_CYCLES clocks
    assign blink_tick = (blink_cnt >= 32'(BLINK_CYCLES - 1));
    always_comb begin
        next_blink_cnt = blink_cnt + 32'h1;
        if (blink_tick) begin
            next_blink_cnt = 32'h0;
        end
    end

    // divider register
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            blink_cnt <= 32'h0;
        end else begin
            blink_cnt <= next_blink_cnt;
        end
    end

    // slow toggle advances only when the divider enables it
    always_comb begin
        next_blink = blink;
        if (blink_tick) begin
            next_blink = !blink;
        end
    end

    // toggle register
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            blink <= 1'b0;
        end else begin
            blink <= next_blink;
        end
    end

    // outputs; readiness levels come straight from the boot timer
    assign o_rdata = rdata;
    assign o_rvalid = rvalid;
    assign o_cmd_error = cmd_err;
    assign o_device_output = out_image;
    assign o_restore_defaults = restore;
    assign o_conn_ready = boot_cnt >= 32'(CONN_CYCLES);
    assign o_cyclic_ready = boot_cnt >= 32'(CYCLIC_CYCLES);
    assign o_wdog_timeout = wdog;
    assign o_wdog_auto_confirm = 1'b1; // only auto confirm is offered
    // network lamp steady green once booted, never yellow
    assign o_net_lamp = '{green: o_cyclic_ready, yellow: 1'b0};
    // ready lamp flashes yellow all through an update
    assign o_rdy_lamp = '{green: !i_fw_update && o_cyclic_ready,
        yellow: i_fw_update && blink};
endmodule // fbio_regs

// File: verif/fbio_regs_properties.sv
`timescale 1ns/1ns
module fbio_regs_properties import fbio_pkg::*; (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire fbio_req_t i_req,
    input wire logic [15:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_cmd_error,
    input wire logic [7:0] i_device_input,
    input wire logic [7:0] o_device_output,
    input wire logic [1:0] i_short_group,
    input wire logic [3:0] i_rotary,
    input wire logic o_restore_defaults,
    input wire logic o_conn_ready,
    input wire logic o_cyclic_ready,
    input wire fbio_lamp_t o_net_lamp
);
    // one domain, so clock and reset are stated once
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    read_answer_a: assert property (i_req.rd |=> o_rvalid) else $error("no read answer");
    input_map_a: assert property (i_req.rd && i_req.addr == FBIO_ADDR_INPUT
        |=> o_rdata == {FBIO_BYTE_ZERO, $past(i_device_input)}) else $error("input word");
    output_map_a: assert property (i_req.wr && i_req.addr == FBIO_ADDR_OUTPUT
        && i_rotary != FBIO_ROTARY_DEFAULTS |=> o_device_output == $past(i_req.wdata[7:0]))
        else $error("output");
    low_group_a: assert property (i_short_group[0] ##1
        (i_req.rd && i_req.addr == FBIO_ADDR_FAULT_LOC) |=> o_rdata == 16'h0001) else $error("loc");
    cmd_error_a: assert property (i_req.wr && i_req.addr == FBIO_ADDR_CMD
        && $countones(i_req.wdata) != 1 |=> o_cmd_error) else $error("command error");
    restore_a: assert property (o_restore_defaults == (i_rotary == FBIO_ROTARY_DEFAULTS))
        else $error("restore");
    boot_order_a: assert property ($rose(o_cyclic_ready) |-> o_conn_ready)
        else $error("boot order");
    net_green_a: assert property (o_cyclic_ready |-> o_net_lamp.green)
        else $error("net lamp");
    cover property (o_cmd_error);
    cover property (o_restore_defaults);
    cover property (o_cyclic_ready);
endmodule // fbio_regs_properties
bind fbio_regs fbio_regs_properties props (.i_clock, .i_rst, .i_req, .o_rdata, .o_rvalid,
    .o_cmd_error, .i_device_input, .o_device_output, .i_short_group, .i_rotary,
    .o_restore_defaults, .o_conn_ready, .o_cyclic_ready, .o_net_lamp);

// File: verif/fbio_client.sv
`timescale 1ns/1ns
// client stand-in; a released request shows inverted junk, not its last value
module fbio_client import fbio_pkg::*; (
    input wire logic i_clock,
    input wire logic i_rvalid,
    input wire logic [15:0] i_rdata,
    output fbio_req_t o_req
);
    initial o_req = '0;
    // one-cycle strobe; command words hold one bit unless a refusal is wanted
    task automatic xfer(input logic w, input logic [15:0] a, d, output logic [15:0] q);
        @(negedge i_clock) o_req = '{w, ~w, a, d};
        @(negedge i_clock) o_req = '{1'b0, 1'b0, ~a, ~d};
        q = i_rvalid ? i_rdata : 16'hDEAD; // answer stands this cycle only
    endtask
endmodule // fbio_client

// File: verif/fbio_regs_bench.sv
`timescale 1ns/1ns
module fbio_regs_bench import fbio_pkg::*;;
    logic i_clock, i_rst, o_rvalid, o_cmd_error, o_restore_defaults, o_conn_ready;
    logic o_cyclic_ready, o_wdog_auto_confirm, i_fw_update;
    logic [15:0] o_rdata, o_wdog_timeout, q;
    logic [7:0] i_device_input, o_device_output;
    logic [3:0] i_rotary;
    logic [1:0] i_short_group;
    fbio_req_t i_req;
    fbio_lamp_t o_net_lamp, o_rdy_lamp;
    int miscompares, samples_checked, hi;
    fbio_regs #(.CONN_CYCLES(20), .CYCLIC_CYCLES(40), .BLINK_CYCLES(4)) DUT (.i_clock, .i_rst,
        .i_req, .o_rdata, .o_rvalid, .o_cmd_error, .i_device_input, .o_device_output,
        .i_short_group, .i_rotary, .i_fw_update, .o_restore_defaults, .o_conn_ready,
        .o_cyclic_ready, .o_wdog_timeout, .o_wdog_auto_confirm, .o_net_lamp, .o_rdy_lamp);
    fbio_client cl (.i_clock, .i_rvalid(o_rvalid), .i_rdata(o_rdata), .o_req(i_req));
    task automatic chk(input string n, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    // read over the link and compare the whole word
    task automatic rdc(input string n, input logic [15:0] a, e);
        cl.xfer(1'b0, a, 16'h0000, q);
        chk(n, e, q);
    endtask
    task automatic results;
        $display("checked %0d, miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    // about 120 cycles are needed; this cuts a hang
    initial begin
        #100000;
        miscompares++;
        results();
    end
    initial begin
        {i_rst, i_fw_update, i_short_group, i_rotary, i_device_input} = {1'b1, 15'h0000};
        repeat (4) @(negedge i_clock);
        i_rst = 1'b0;
        chk("wdog", 16'h0000, o_wdog_timeout);
        chk("confirm", 16'h0001, {15'h0000, o_wdog_auto_confirm});
        for (int i = 0; i < 8; i++) begin
            i_device_input = 8'h01 << i;
            rdc("input", FBIO_ADDR_INPUT, {8'h00, 8'h01 << i});
        end
        cl.xfer(1'b1, FBIO_ADDR_OUTPUT, 16'hAB55, q);
        chk("outputs", 16'h0055, {8'h00, o_device_output});
        rdc("out word", FBIO_ADDR_OUTPUT, 16'h0055);
        cl.xfer(1'b1, FBIO_ADDR_WDOG, 16'h12AB, q);
        rdc("word", FBIO_ADDR_WDOG, 16'h12AB);
        rdc("unmapped", 16'h0100, 16'h0000);
        $display("map test done");
        rdc("loc idle", FBIO_ADDR_FAULT_LOC, 16'h0000);
        for (int i = 1; i < 4; i++) begin
            i_short_group = 2'(i);
            rdc("loc", FBIO_ADDR_FAULT_LOC, (i == 2) ? 16'h0002 : 16'h0001);
            rdc("diag", FBIO_ADDR_DIAG, 16'h0001);
            i_short_group = 2'h0;
            cl.xfer(1'b1, FBIO_ADDR_CMD, 16'h0080, q);
            rdc("loc clear", FBIO_ADDR_FAULT_LOC, 16'h0000);
        end
        cl.xfer(1'b1, FBIO_ADDR_CMD, 16'h0081, q);
        chk("cmd err", 16'h0001, {15'h0000, o_cmd_error});
        $display("fault test done");
        i_rotary = 4'hF;
        @(negedge i_clock);
        chk("restore", 16'h0001, {15'h0000, o_restore_defaults});
        rdc("wdog dflt", FBIO_ADDR_WDOG, 16'h0000);
        chk("out dflt", 16'h0000, {8'h00, o_device_output});
        i_rotary = 4'h0;
        // second reset in mid-run: readiness counted from its release
        i_rst = 1'b1;
        @(negedge i_clock);
        i_rst = 1'b0;
        repeat (19) @(negedge i_clock);
        chk("early", 16'h0000, {14'h0000, o_conn_ready, o_cyclic_ready});
        chk("net early", 16'h0000, {15'h0000, o_net_lamp.green});
        @(negedge i_clock);
        chk("conn", 16'h0002, {14'h0000, o_conn_ready, o_cyclic_ready});
        repeat (19) @(negedge i_clock);
        chk("cyc early", 16'h0002, {14'h0000, o_conn_ready, o_cyclic_ready});
        @(negedge i_clock);
        chk("ready", 16'h0003, {14'h0000, o_conn_ready, o_cyclic_ready});
        chk("net", 16'h0001, {15'h0000, o_net_lamp.green});
        $display("boot test done");
        chk("no blink", 16'h0000, {15'h0000, o_rdy_lamp.yellow});
        i_fw_update = 1'b1;
        hi = 0;
        repeat (20) begin
            @(negedge i_clock);
            if (o_rdy_lamp.yellow === 1'b1) hi++;
        end
        chk("blink", 16'h0001, {15'h0000, hi >= 8 && hi <= 12});
        $display("mode test done");
        results();
    end
endmodule // fbio_regs_bench
